// file: hw/event_log_pulse_tally.sv
// How it works
// - Log a record for every accepted change the channel's edge selection allows, while the write buffer is not full.
// - A record holds channel number and the current time tag.
// - Each log buffer holds up to 3000 records.
// - Logging continues into the other buffer while the host reads one.
// - Buffer full and count equal to host threshold raise events.
// - Every channel has its own pulse tally counter.
// - The tally counts both rising and falling changes.
// - Tally reaching 65535 sets a flag and may interrupt.
// - Base jumpers compare address bits 23 to 14 (short access: jumpers 1 to 0 with bits 15 to 14), an 8 Kword window.
// - Jumpers choose user only, supervisor only or either access.
// - Self-test runs after reset and when the host sets test mode.
// - Self-test pass or fail is readable in the control word.
// - The LED is lit after self-test whatever its outcome.
// - Reset gives 1 ms debounce, LED lit and test mode set.
// - Software may switch the LED on and off in any cycle but T_CHECK, where self-test lights it.
// - Interrupt on a chosen level; acknowledge returns a byte vector.
// - One requester, withdrawn when its interrupt is acknowledged.
// - Sources: edge, tag rollover, tally rollover, buffer full, threshold.
// - Each source has its own enable; only enabled sources interrupt.
// - Per channel edge choice: rising, falling, both or off.
// - Time tag ticks each ms, host presets it, wraps to 0 with a flag.
`timescale 1ns/10ps
`default_nettype none
module event_log_pulse_tally #(
	parameter int TICK_COUNT = evlog_pkg::TICK_CYCLES
) (
	input  wire logic                       i_clock,
	input  wire logic                       i_rst,
	input  wire evlog_pkg::bus_req_t        i_bus,
	output logic [15:0]                     o_rdata,
	input  wire logic [evlog_pkg::CHANNELS-1:0] i_inputs,
	input  wire logic [9:0]                 i_base_jumper,
	input  wire logic [1:0]                 i_priv_jumper,
	input  wire logic                       i_iack,
	input  wire logic [2:0]                 i_iack_level,
	output logic [6:0]                      o_irq_req,
	output logic [7:0]                      o_vector,
	output logic                            o_vector_valid,
	output logic                            o_led
);
	import evlog_pkg::*;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] be);
		merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction

	function automatic logic [5:0] first_set(input logic [CHANNELS-1:0] v);
		first_set = 6'h00;
		for (int k = CHANNELS - 1; k >= 0; k--) begin
			if (v[k]) begin
				first_set = k[5:0];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////
	logic [21:0]        log_mem [2][LOG_DEPTH];
	logic [15:0]        tally [CHANNELS];
	logic [15:0]        bounce_cnt [CHANNELS];
	logic [11:0]        cnt [2];
	logic [CHANNELS-1:0] level;
	logic [CHANNELS-1:0] pend;
	logic [127:0]       edge_sel;
	logic [16:0]        tick_cnt;
	logic [15:0]        tag;
	logic [15:0]        debounce;
	logic [11:0]        thresh;
	logic [11:0]        log_idx;
	logic [NSRC-1:0]    flags;
	logic [NSRC-1:0]    int_en;
	logic [2:0]         irq_level;
	logic [7:0]         vector;
	logic               armed;
	logic               test_mode;
	logic               test_pass;
	logic               host_buf;
	logic [21:0]        test_rd [2];
	test_state_t        test_state;

	////////////////////////////////////////////////////////////////
	// Address and modifier decode
	wire        is_std = i_bus.am == AM_STD_USER || i_bus.am == AM_STD_SUPER;
	wire        is_short = i_bus.am == AM_SHORT_USER || i_bus.am == AM_SHORT_SUPER;
	wire        is_super = i_bus.am == AM_STD_SUPER || i_bus.am == AM_SHORT_SUPER;
	wire        priv_ok = is_super ? i_priv_jumper[1] : i_priv_jumper[0];
	wire        base_ok = is_std ? i_bus.addr[23:14] == i_base_jumper
		: i_bus.addr[15:14] == i_base_jumper[1:0];
	wire        hit = (is_std || is_short) && priv_ok && base_ok;
	wire [13:0] off = {i_bus.addr[13:1], 1'b0};
	wire        wr = i_bus.wr && hit;
	wire        rd = i_bus.rd && hit;
	wire        wr_lo = wr && i_bus.be[0];
	wire        wr_hi = wr && i_bus.be[1];
	wire        in_edge = off[13:4] == EDGE_REGION;
	wire        in_tally = off[13:7] == TALLY_REGION;
	wire [2:0]  edge_word = off[3:1];
	wire [5:0]  tally_ch = off[6:1];
	wire        wbuf = ~host_buf;
	wire [11:0] wcnt = cnt[wbuf];

	// Register read values
	wire [15:0] csr_val = {3'h0, flags, 4'h0, test_pass, host_buf, o_led, test_mode};
	wire [21:0] rec_rd = log_mem[host_buf][log_idx];
	wire [15:0] edge_val = edge_sel[edge_word*16 +: 16];
	logic [15:0] next_rdata;
	always_comb begin
		next_rdata = 16'h0000;
		if (rd) begin
			unique case (1'b1)
				off == OFF_CSR:      next_rdata = csr_val;
				off == OFF_INT_CTRL: next_rdata = {5'h00, irq_level, 3'h0, int_en};
				off == OFF_VECTOR:   next_rdata = {8'h00, vector};
				off == OFF_THRESH:   next_rdata = {4'h0, thresh};
				off == OFF_TAG:      next_rdata = tag;
				off == OFF_DEBOUNCE: next_rdata = debounce;
				off == OFF_COUNT:    next_rdata = {4'h0, cnt[host_buf]};
				off == OFF_LOG_IDX:  next_rdata = {4'h0, log_idx};
				off == OFF_LOG_CHAN: next_rdata = {10'h000, rec_rd[21:16]};
				off == OFF_LOG_TAG:  next_rdata = rec_rd[15:0];
				in_edge:             next_rdata = edge_val;
				in_tally:            next_rdata = tally[tally_ch];
				default:             next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Millisecond tick and time tag
	wire tick = tick_cnt == 17'(TICK_COUNT - 1);
	wire tag_wr = (wr_lo || wr_hi) && off == OFF_TAG;
	wire tag_roll = tick && tag == TAG_MAX && !tag_wr;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			tick_cnt <= 17'h00000;
			tag <= 16'h0000;
		end else begin
			tick_cnt <= tick ? 17'h00000 : tick_cnt + 17'h00001;
			if (tag_wr) begin
				tag <= merge(tag, i_bus.wdata, i_bus.be);
			end else if (tick) begin
				tag <= tag + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Per channel debounce, sampled on the tick
	logic [CHANNELS-1:0] accept;
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			accept[c] = tick && i_inputs[c] != level[c] && bounce_cnt[c] + 16'h0001 >= debounce;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			level <= '0;
			for (int c = 0; c < CHANNELS; c++) begin
				bounce_cnt[c] <= 16'h0000;
			end
		end else if (tick) begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (i_inputs[c] == level[c] || accept[c]) begin
					bounce_cnt[c] <= 16'h0000;
				end else begin
					bounce_cnt[c] <= bounce_cnt[c] + 16'h0001;
				end
				if (accept[c]) begin
					level[c] <= i_inputs[c];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Scanner: one pending channel per cycle into tally and log
	wire       testing = test_state != T_IDLE;
	wire       scan_go = |pend && !testing;
	wire [5:0] scan_ch = first_set(pend);
	wire [1:0] sel = edge_sel[scan_ch*2 +: 2];
	wire       rising = level[scan_ch];
	wire       log_ok = sel == EDGE_BOTH || (rising ? sel == EDGE_RISE : sel == EDGE_FALL);
	wire       log_wr = scan_go && log_ok && wcnt < LOG_DEPTH;
	wire       tally_top = scan_go && tally[scan_ch] == TALLY_MAX - 16'h0001;
	wire [CHANNELS-1:0] scan_clr = scan_go ? CHANNELS'(1) << scan_ch : '0;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pend <= '0;
			for (int c = 0; c < CHANNELS; c++) begin
				tally[c] <= 16'h0000;
			end
		end else begin
			pend <= (pend & ~scan_clr) | accept;  // New changes win over the clear
			if (scan_go) begin
				tally[scan_ch] <= tally[scan_ch] + 16'h0001;
			end
		end
	end

	// Log memory: record writes and self-test pattern
	always_ff @(posedge i_clock) begin
		if (test_state == T_WRITE) begin
			log_mem[0][0] <= TEST_PATTERN;
			log_mem[1][0] <= ~TEST_PATTERN;
		end else if (log_wr) begin
			log_mem[wbuf][wcnt] <= {scan_ch, tag};
		end
		test_rd[0] <= log_mem[0][0];
		test_rd[1] <= log_mem[1][0];
	end

	////////////////////////////////////////////////////////////////
	// Events of this cycle
	logic [NSRC-1:0] ev;
	always_comb begin
		ev = '0;
		ev[SRC_EDGE] = log_wr;
		ev[SRC_TAG_ROLL] = tag_roll;
		ev[SRC_TALLY_ROLL] = tally_top;
		ev[SRC_FULL] = log_wr && wcnt + 12'h001 == LOG_DEPTH;
		ev[SRC_THRESH] = log_wr && wcnt + 12'h001 == thresh;
	end

	// Control/status word, counts and self-test
	wire csr_wr_lo = wr_lo && off == OFF_CSR;
	wire [NSRC-1:0] flag_clr = wr_hi && off == OFF_CSR ? i_bus.wdata[CSR_FLAG_LO +: NSRC] : '0;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			test_mode <= 1'b1;
			o_led <= 1'b1;
			test_pass <= 1'b0;
			host_buf <= 1'b0;
			flags <= '0;
			cnt[0] <= 12'h000;
			cnt[1] <= 12'h000;
			test_state <= T_IDLE;
		end else begin
			flags <= (flags & ~flag_clr) | ev;
			if (csr_wr_lo) begin
				test_mode <= test_mode | i_bus.wdata[CSR_TEST];
				o_led <= i_bus.wdata[CSR_LED];
				host_buf <= i_bus.wdata[CSR_HOSTBUF];
				if (i_bus.wdata[CSR_HOSTBUF] != host_buf) begin
					cnt[host_buf] <= 12'h000;  // Newly filled buffer starts empty
				end
			end
			if (log_wr) begin
				cnt[wbuf] <= wcnt + 12'h001;
			end
			unique case (test_state)
				T_IDLE:  test_state <= test_mode ? T_WRITE : T_IDLE;
				T_WRITE: test_state <= T_READ;
				T_READ:  test_state <= T_CHECK;
				T_CHECK: begin
					test_pass <= test_rd[0] == TEST_PATTERN && test_rd[1] == ~TEST_PATTERN;
					test_mode <= 1'b0;
					o_led <= 1'b1;
					cnt[0] <= 12'h000;
					cnt[1] <= 12'h000;
					test_state <= T_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Byte-lane merged write values of the narrow registers
	wire [15:0] int_ctrl_wr = merge({5'h00, irq_level, 3'h0, int_en}, i_bus.wdata, i_bus.be);
	wire [15:0] vector_wr = merge({8'h00, vector}, i_bus.wdata, i_bus.be);
	wire [15:0] thresh_wr = merge({4'h0, thresh}, i_bus.wdata, i_bus.be);
	wire [15:0] log_idx_wr = merge({4'h0, log_idx}, i_bus.wdata, i_bus.be);

	// Plain host registers
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			int_en <= '0;
			irq_level <= 3'h0;
			vector <= 8'h00;
			thresh <= 12'h000;
			debounce <= DEBOUNCE_RESET;
			log_idx <= 12'h000;
			edge_sel <= '0;
		end else if (wr) begin
			unique case (1'b1)
				off == OFF_INT_CTRL: {irq_level, int_en} <= {int_ctrl_wr[10:8], int_ctrl_wr[4:0]};
				off == OFF_VECTOR:   vector <= vector_wr[7:0];
				off == OFF_THRESH:   thresh <= thresh_wr[11:0];
				off == OFF_DEBOUNCE: debounce <= merge(debounce, i_bus.wdata, i_bus.be);
				off == OFF_LOG_IDX:  log_idx <= log_idx_wr[11:0];
				in_edge:             edge_sel[edge_word*16 +: 16] <= merge(edge_val, i_bus.wdata,
					i_bus.be);
				default:             ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Single release-on-acknowledge requester
	wire irq_on = armed && |(flags & int_en) && irq_level != 3'h0;
	wire vec_take = irq_on && i_iack && i_iack_level == irq_level;
	assign o_irq_req = irq_on ? 7'(7'h01 << (irq_level - 3'h1)) : 7'h00;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			armed <= 1'b0;
			o_vector <= 8'h00;
			o_vector_valid <= 1'b0;
		end else begin
			armed <= |(ev & int_en) || (armed && !vec_take);
			o_vector_valid <= vec_take;
			if (vec_take) begin
				o_vector <= vector;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	chk_log_capacity: assert property (cnt[0] <= LOG_DEPTH && cnt[1] <= LOG_DEPTH)
		else $error("log count beyond buffer size");
	chk_log_skip: assert property (scan_go && !log_ok && !csr_wr_lo |=>
		cnt[wbuf] == $past(wcnt)) else $error("excluded edge was logged");
	chk_log_write: assert property (log_wr && !csr_wr_lo |=>
		cnt[wbuf] == $past(wcnt) + 12'h001) else $error("record not counted");
	chk_tag_wrap: assert property (tag_roll |=> tag == 16'h0000 && flags[SRC_TAG_ROLL])
		else $error("time tag did not wrap");
	chk_tally_flag: assert property (tally_top |=> flags[SRC_TALLY_ROLL])
		else $error("tally maximum not flagged");
	chk_roak_release: assert property (vec_take && !(|(ev & int_en)) |=>
		o_vector_valid && o_irq_req == 7'h00) else $error("request held after acknowledge");
	chk_irq_enabled: assert property (o_irq_req != 7'h00 |-> |(flags & int_en))
		else $error("interrupt from disabled source");
	chk_unmapped_read: assert property (i_bus.rd && !hit |=> o_rdata == 16'h0000)
		else $error("unselected read returned data");
	chk_test_led: assert property (test_state == T_CHECK |=> o_led && !test_mode
		&& test_state == T_IDLE) else $error("self-test end wrong");
	chk_test_start: assert property (!i_rst && test_mode && test_state == T_IDLE |=>
		##2 test_state == T_CHECK) else $error("self-test did not run");

	cov_vector: cover property (vec_take);
	cov_full: cover property (ev[SRC_FULL]);
	cov_test_pass: cover property (test_state == T_CHECK ##1 test_pass);
endmodule
`default_nettype wire

// file: pkg/evlog_pkg.sv
`default_nettype none
package evlog_pkg;
	localparam int CHANNELS = 64;
	localparam logic [11:0] LOG_DEPTH = 12'hBB8;      // Records per buffer
	localparam logic [15:0] TALLY_MAX = 16'hFFFF;
	localparam logic [15:0] TAG_MAX = 16'hFFFF;
	localparam int TICK_NS = 1000000;                  // Sampling tick, 1 ms
	localparam int CLOCK_NS = 10;
	localparam int TICK_CYCLES = TICK_NS / CLOCK_NS;
	localparam logic [15:0] DEBOUNCE_RESET = 16'h0001; // Ticks of debounce
	localparam logic [21:0] TEST_PATTERN = 22'h2A5A5A;
	// Address modifiers
	localparam logic [5:0] AM_STD_USER = 6'h39;
	localparam logic [5:0] AM_STD_SUPER = 6'h3D;
	localparam logic [5:0] AM_SHORT_USER = 6'h29;
	localparam logic [5:0] AM_SHORT_SUPER = 6'h2D;
	// Register byte offsets inside the board window
	localparam logic [13:0] OFF_CSR = 14'h0000;
	localparam logic [13:0] OFF_INT_CTRL = 14'h0002;
	localparam logic [13:0] OFF_VECTOR = 14'h0004;
	localparam logic [13:0] OFF_THRESH = 14'h0006;
	localparam logic [13:0] OFF_TAG = 14'h0008;
	localparam logic [13:0] OFF_DEBOUNCE = 14'h000A;
	localparam logic [13:0] OFF_COUNT = 14'h000C;
	localparam logic [13:0] OFF_LOG_IDX = 14'h000E;
	localparam logic [13:0] OFF_LOG_CHAN = 14'h0010;
	localparam logic [13:0] OFF_LOG_TAG = 14'h0012;
	localparam logic [9:0] EDGE_REGION = 10'h002;      // 0x0020..0x002E
	localparam logic [6:0] TALLY_REGION = 7'h02;       // 0x0100..0x017E
	// Control/status word bits
	localparam int CSR_TEST = 0;
	localparam int CSR_LED = 1;
	localparam int CSR_HOSTBUF = 2;
	localparam int CSR_PASS = 3;
	localparam int CSR_FLAG_LO = 8;
	// Event sources, also interrupt enable bits
	localparam int SRC_EDGE = 0;
	localparam int SRC_TAG_ROLL = 1;
	localparam int SRC_TALLY_ROLL = 2;
	localparam int SRC_FULL = 3;
	localparam int SRC_THRESH = 4;
	localparam int NSRC = 5;
	// Edge select codes
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	typedef enum logic [3:0] {
		T_IDLE  = 4'h1,
		T_WRITE = 4'h2,
		T_READ  = 4'h4,
		T_CHECK = 4'h8
	} test_state_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [5:0]  am;
		logic [15:0] wdata;
		logic [1:0]  be;    // [1] upper byte D15..D8, [0] lower byte
		logic        wr;
		logic        rd;
	} bus_req_t;
endpackage
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host side of the board: bus master and interrupt handler
module host_model (
	input  wire logic           i_clock,
	input  wire logic [15:0]    i_rdata,
	input  wire logic [7:0]     i_vector,
	input  wire logic           i_vector_valid,
	output evlog_pkg::bus_req_t o_bus,
	output logic                o_iack,
	output logic [2:0]          o_iack_level
);
	import evlog_pkg::*;

	// Idle bus at time zero
	initial begin
		o_bus = '0;
		o_iack = 1'b0;
		o_iack_level = 3'h0;
	end

	// One strobe cycle; read data are taken in the cycle after the strobe
	task automatic cycle(input logic [5:0] am, input logic [23:0] ad, input logic [15:0] d,
			input logic [1:0] be, input logic is_rd, output logic [15:0] q);
		@(posedge i_clock);
		o_bus.am <= am;
		o_bus.addr <= ad;
		o_bus.wdata <= d;
		o_bus.be <= be;
		o_bus.wr <= !is_rd;
		o_bus.rd <= is_rd;
		@(posedge i_clock);
		o_bus.wr <= 1'b0;
		o_bus.rd <= 1'b0;
		// Released lines no longer show the last value
		o_bus.addr <= ~ad;
		o_bus.wdata <= ~d;
		#1 q = i_rdata;
	endtask

	// Acknowledge cycle at one level; vector is taken the cycle after
	task automatic ack(input logic [2:0] lv, output logic ok, output logic [7:0] vec);
		@(posedge i_clock);
		o_iack <= 1'b1;
		o_iack_level <= lv;
		@(posedge i_clock);
		o_iack <= 1'b0;
		o_iack_level <= 3'h0;
		#1 ok = i_vector_valid;
		vec = i_vector;
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
	$display("Error %s expected %h seen %h", name, exp, got); end end
module tb;
	import evlog_pkg::*;
	localparam int TICKS = 20;
	localparam logic [23:0] BASE = 24'h554000;
	logic i_clock, i_rst, i_iack, o_vector_valid, o_led, ok;
	logic [2:0] i_iack_level;
	logic [6:0] o_irq_req;
	logic [7:0] o_vector, vec;
	logic [15:0] o_rdata, q;
	logic [63:0] i_inputs;
	logic [9:0] i_base_jumper;
	logic [1:0] i_priv_jumper;
	bus_req_t i_bus;
	int fails, check_count;
	logic [15:0] tags [4];
	logic [5:0] am_t [8] = '{6'h39, 6'h3D, 6'h29, 6'h2D, 6'h09, 6'h29, 6'h39, 6'h39};
	logic [23:0] ad_t [8] = '{BASE | 24'h6, BASE | 24'h6, 24'h004006, 24'h004006,
		BASE | 24'h6, 24'h00C006, 24'h000006, BASE | 24'h300};
	logic [15:0] ex_t [8] = '{16'h0357, 16'h0357, 16'h0357, 16'h0357, 16'h0, 16'h0, 16'h0, 16'h0};
	logic [15:0] tl_t [4] = '{16'h2, 16'h3, 16'h2, 16'h2};
	logic [15:0] ch_t [4] = '{16'h0, 16'h1, 16'h2, 16'h2};

	////////////////////////////////////////////////////////////////////////////////
	// Clock and instances
	always #5 i_clock = ~i_clock;

	event_log_pulse_tally #(.TICK_COUNT(TICKS)) event_log_pulse_tally_i (
		.i_clock(i_clock), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
		.i_inputs(i_inputs), .i_base_jumper(i_base_jumper), .i_priv_jumper(i_priv_jumper),
		.i_iack(i_iack), .i_iack_level(i_iack_level), .o_irq_req(o_irq_req),
		.o_vector(o_vector), .o_vector_valid(o_vector_valid), .o_led(o_led));

	host_model host_model_i (
		.i_clock(i_clock), .i_rdata(o_rdata), .i_vector(o_vector),
		.i_vector_valid(o_vector_valid), .o_bus(i_bus), .o_iack(i_iack),
		.o_iack_level(i_iack_level));

	////////////////////////////////////////////////////////////////////////////////
	// Access helpers
	task automatic wreg(input logic [13:0] off, input logic [15:0] d);
		host_model_i.cycle(6'h39, BASE | {10'h0, off}, d, 2'b11, 1'b0, q);
	endtask

	task automatic probe(input string name, input logic [5:0] am, input logic [23:0] ad,
			input logic [15:0] e);
		host_model_i.cycle(am, ad, 16'h0, 2'b11, 1'b1, q);
		`CHECK(name, e, q)
	endtask

	task automatic expect_reg(input string name, input logic [13:0] off, input logic [15:0] e);
		probe(name, 6'h39, BASE | {10'h0, off}, e);
	endtask

	task automatic ticks(input int n);
		repeat (n * TICKS) @(posedge i_clock);
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Hang guard
	initial begin
		repeat (60000) @(posedge i_clock);
		fails++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		i_clock = 1'b0;
		i_rst = 1'b1;
		i_inputs = 64'h0;
		i_base_jumper = 10'h155;
		i_priv_jumper = 2'b11;
		repeat (5) @(posedge i_clock);
		`CHECK("led_in_reset", 1'b1, o_led)
		`CHECK("irq_in_reset", 7'h00, o_irq_req)
		i_rst <= 1'b0;
		repeat (10) @(posedge i_clock);
		expect_reg("csr_after_reset", OFF_CSR, 16'h000A);
		expect_reg("debounce_reset", OFF_DEBOUNCE, 16'h0001);
		wreg(OFF_CSR, 16'h0000);
		`CHECK("led_off", 1'b0, o_led)
		wreg(OFF_CSR, 16'h0002);
		`CHECK("led_on", 1'b1, o_led)
		wreg(OFF_CSR, 16'h0003);
		repeat (8) @(posedge i_clock);
		expect_reg("csr_retest", OFF_CSR, 16'h000A);
		// Address, modifier and privilege decoding
		wreg(OFF_THRESH, 16'h1357);
		for (int k = 0; k < 8; k++) begin
			probe("decode", am_t[k], ad_t[k], ex_t[k]);
		end
		@(posedge i_clock) i_priv_jumper <= 2'b01;
		probe("user_only_super", 6'h3D, BASE | 24'h6, 16'h0);
		probe("user_only_user", 6'h39, BASE | 24'h6, 16'h0357);
		@(posedge i_clock) i_priv_jumper <= 2'b10;
		probe("super_only_user", 6'h29, 24'h004006, 16'h0);
		probe("super_only_super", 6'h2D, 24'h004006, 16'h0357);
		@(posedge i_clock) i_priv_jumper <= 2'b11;
		// Byte lanes at odd and even addresses
		host_model_i.cycle(6'h39, BASE | 24'h7, 16'h0077, 2'b01, 1'b0, q);
		expect_reg("byte_odd", OFF_THRESH, 16'h0377);
		host_model_i.cycle(6'h39, BASE | 24'h6, 16'h5500, 2'b10, 1'b0, q);
		expect_reg("byte_even", OFF_THRESH, 16'h0577);
		// Time tag wrap
		wreg(OFF_TAG, 16'hFFFF);
		ticks(1);
		repeat (5) @(posedge i_clock);
		host_model_i.cycle(6'h39, BASE | 24'h8, 16'h0, 2'b11, 1'b1, q);
		`CHECK("tag_wrapped", 1'b1, q <= 16'h0001)
		host_model_i.cycle(6'h39, BASE, 16'h0, 2'b11, 1'b1, q);
		`CHECK("tag_roll_flag", 1'b1, q[9])
		// Edge selection, logging and tallies with interrupts masked
		@(posedge i_clock) i_inputs <= 64'h2;
		ticks(3);
		wreg(14'h0020, 16'h0039);
		@(posedge i_clock) i_inputs <= 64'hD;
		ticks(6);
		@(posedge i_clock) i_inputs <= 64'h2;
		ticks(6);
		`CHECK("irq_masked", 7'h00, o_irq_req)
		for (int k = 0; k < 4; k++) begin
			expect_reg("tally", 14'h0100 + 14'(2 * k), tl_t[k]);
		end
		wreg(OFF_CSR, 16'h0006);
		expect_reg("count_logged", OFF_COUNT, 16'h0004);
		for (int k = 0; k < 4; k++) begin
			wreg(OFF_LOG_IDX, 16'(k));
			expect_reg("record_chan", OFF_LOG_CHAN, ch_t[k]);
			host_model_i.cycle(6'h39, BASE | 24'h12, 16'h0, 2'b11, 1'b1, tags[k]);
		end
		`CHECK("tag_same_tick", tags[0], tags[1])
		`CHECK("tag_later_tick", 1'b1, tags[3] !== tags[0])
		// Interrupt request, wrong level, acknowledge and vector
		wreg(OFF_VECTOR, 16'h00A5);
		wreg(OFF_INT_CTRL, 16'h0301);
		@(posedge i_clock) i_inputs <= 64'h6;
		ticks(6);
		`CHECK("irq_level", 7'h04, o_irq_req)
		host_model_i.ack(3'h2, ok, vec);
		`CHECK("ack_wrong_level", 1'b0, ok)
		`CHECK("irq_kept", 7'h04, o_irq_req)
		host_model_i.ack(3'h3, ok, vec);
		`CHECK("ack_valid", 1'b1, ok)
		`CHECK("vector", 8'hA5, vec)
		`CHECK("irq_released", 7'h00, o_irq_req)
		expect_reg("host_buf_kept", OFF_COUNT, 16'h0004);
		wreg(OFF_CSR, 16'h0002);
		expect_reg("other_buf", OFF_COUNT, 16'h0001);
		// Fill a buffer past capacity with threshold and full interrupts
		wreg(OFF_THRESH, 16'h0005);
		wreg(OFF_INT_CTRL, 16'h0318);
		for (int k = 0; k < 8; k++) begin
			wreg(14'h0020 + 14'(2 * k), 16'hFFFF);
		end
		// Each toggle is taken at the next tick and all 64 channels scan out before the next one
		repeat (50) begin
			@(posedge i_clock) i_inputs <= ~i_inputs;
			repeat (90) @(posedge i_clock);
		end
		repeat (100) @(posedge i_clock);
		wreg(OFF_CSR, 16'h0006);
		expect_reg("full_count", OFF_COUNT, {4'h0, LOG_DEPTH});
		host_model_i.cycle(6'h39, BASE, 16'h0, 2'b11, 1'b1, q);
		`CHECK("full_flag", 1'b1, q[11])
		`CHECK("thresh_flag", 1'b1, q[12])
		`CHECK("irq_full", 7'h04, o_irq_req)
		tally_and_finish();
	end
endmodule
`default_nettype wire
